// ---- logic/evi_pkg.sv ----
// Purpose: Shared constants for the encoder velocity and event block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Event bit positions are common to enable, raw and masked views
package evi_pkg;
	localparam logic [11:0] EVI_OFS_VELOCITY = 12'h01C;
	localparam logic [11:0] EVI_OFS_IRQ_EN = 12'h020;
	localparam logic [11:0] EVI_OFS_RAW = 12'h024;
	localparam logic [11:0] EVI_OFS_MASKED = 12'h028;
	localparam logic [11:0] EVI_OFS_CONTROL = 12'h000;
	localparam logic [11:0] EVI_OFS_LOAD = 12'h010;
	localparam logic [11:0] EVI_OFS_TIME = 12'h014;
	localparam logic [11:0] EVI_OFS_COUNT = 12'h018;
	localparam int EVI_NUM_EVENTS = 4;
	localparam int EVI_BIT_PHASE_ERR = 3;
	localparam int EVI_BIT_DIR_CHG = 2;
	localparam int EVI_BIT_TIMER = 1;
	localparam int EVI_BIT_INDEX = 0;
	localparam int EVI_BIT_VEL_EN = 5;
	localparam logic [31:0] EVI_RESET_WORD = 32'h0000_0000;
	localparam logic [31:0] EVI_ONE_WORD = 32'h0000_0001;
	localparam logic [3:0] EVI_RESET_EVENTS = 4'h0;
endpackage

// ---- logic/evi_velocity_irq.sv ----
// Purpose: Velocity measurement result and event latches with APB access
// Assumes: Event inputs are single-cycle pulses from logic on pclk
// Notes: Reads return data one cycle after setup; pready is always high in access
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
module evi_velocity_irq
	import evi_pkg::*;
#(
	parameter int DATA_W = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic velocity_pulse,
	input wire logic phase_error_event,
	input wire logic direction_change_event,
	input wire logic index_pulse_event,
	output logic irq
);

	typedef struct packed {
		logic [DATA_W-1:0] control;
		logic [DATA_W-1:0] load;
		logic [DATA_W-1:0] timer;
		logic [DATA_W-1:0] count;
		logic [DATA_W-1:0] velocity;
		logic [EVI_NUM_EVENTS-1:0] irq_en;
		logic [EVI_NUM_EVENTS-1:0] raw;
		logic [31:0] rdata;
		logic ready;
		logic err;
		logic irq;
	} evi_state_t;

	evi_state_t s_q;
	evi_state_t s_d;

	// Decode used only for the error flag; unknown offsets flag an error
	function automatic logic evi_mapped(input logic [11:0] a);
		if (a == EVI_OFS_CONTROL) begin
			return 1'b1;
		end else if (a == EVI_OFS_LOAD || a == EVI_OFS_TIME || a == EVI_OFS_COUNT) begin
			return 1'b1;
		end else if (a == EVI_OFS_VELOCITY || a == EVI_OFS_IRQ_EN) begin
			return 1'b1;
		end else if (a == EVI_OFS_RAW || a == EVI_OFS_MASKED) begin
			return 1'b1;
		end else begin
			return 1'b0;
		end
	endfunction

	logic setup_c;
	logic access_c;
	logic wr_c;
	logic vel_en_c;
	logic expire_c;
	logic [EVI_NUM_EVENTS-1:0] events_c;
	logic [EVI_NUM_EVENTS-1:0] clear_c;
	logic [EVI_NUM_EVENTS-1:0] masked_c;

	// Next-state logic for bus, timer and latches
	always_comb begin
		s_d = s_q;
		setup_c = psel && !penable;
		// A write lands only at the edge where the master sees pready high
		access_c = psel && penable && s_q.ready;
		wr_c = access_c && pwrite;
		vel_en_c = s_q.control[EVI_BIT_VEL_EN];
		// Zero reached while enabled marks the end of a period
		expire_c = vel_en_c && (s_q.timer == EVI_RESET_WORD);

		// Velocity engine freezes entirely while disabled
		if (vel_en_c) begin
			if (expire_c) begin
				s_d.timer = s_q.load;
				s_d.velocity = s_q.count;
				s_d.count = velocity_pulse ? EVI_ONE_WORD : EVI_RESET_WORD;
			end else begin
				s_d.timer = s_q.timer - EVI_ONE_WORD;
				s_d.count = s_q.count + (velocity_pulse ? EVI_ONE_WORD : EVI_RESET_WORD);
			end
		end

		// Event sources in their fixed bit positions
		events_c = EVI_RESET_EVENTS;
		events_c[EVI_BIT_PHASE_ERR] = phase_error_event;
		events_c[EVI_BIT_DIR_CHG] = direction_change_event;
		events_c[EVI_BIT_TIMER] = expire_c;
		events_c[EVI_BIT_INDEX] = index_pulse_event;

		// Only ones written to masked status clear; zeros leave latches alone
		clear_c = EVI_RESET_EVENTS;
		if (wr_c && paddr == EVI_OFS_MASKED) begin
			clear_c = pwdata[EVI_NUM_EVENTS-1:0];
		end
		// Set wins over clear so no event is lost
		s_d.raw = (s_q.raw & ~clear_c) | events_c;

		// Register writes take effect at the access edge, matching the master's view
		if (wr_c) begin
			if (paddr == EVI_OFS_CONTROL) begin
				s_d.control = pwdata;
			end else if (paddr == EVI_OFS_LOAD) begin
				s_d.load = pwdata;
			end else if (paddr == EVI_OFS_IRQ_EN) begin
				s_d.irq_en = pwdata[EVI_NUM_EVENTS-1:0];
			end
		end

		masked_c = s_q.raw & s_q.irq_en;

		// Read mux; reserved upper bits of event registers read zero
		s_d.rdata = EVI_RESET_WORD;
		if (setup_c && !pwrite) begin
			if (paddr == EVI_OFS_CONTROL) begin
				s_d.rdata = s_q.control;
			end else if (paddr == EVI_OFS_LOAD) begin
				s_d.rdata = s_q.load;
			end else if (paddr == EVI_OFS_TIME) begin
				s_d.rdata = s_q.timer;
			end else if (paddr == EVI_OFS_COUNT) begin
				s_d.rdata = s_q.count;
			end else if (paddr == EVI_OFS_VELOCITY) begin
				s_d.rdata = s_q.velocity;
			end else if (paddr == EVI_OFS_IRQ_EN) begin
				s_d.rdata = {{(32-EVI_NUM_EVENTS){1'b0}}, s_q.irq_en};
			end else if (paddr == EVI_OFS_RAW) begin
				s_d.rdata = {{(32-EVI_NUM_EVENTS){1'b0}}, s_q.raw};
			end else if (paddr == EVI_OFS_MASKED) begin
				s_d.rdata = {{(32-EVI_NUM_EVENTS){1'b0}}, masked_c};
			end
		end

		// Zero-wait slave: ready only in the access phase
		s_d.ready = setup_c;
		s_d.err = setup_c && !evi_mapped(paddr);

		// Interrupt output follows masked view from the updated latches
		s_d.irq = |(s_d.raw & s_d.irq_en);
	end

	// All state clears to zero on reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.rdata;
	assign pready = s_q.ready;
	assign pslverr = s_q.err;
	assign irq = s_q.irq;

endmodule // evi_velocity_irq

// ---- verification/evi_props.sv ----
// Purpose: port assertions for the velocity and event block
// Assumes: APB answer one cycle after setup
// Notes: sees the top ports only
`timescale 1ns/1ps
module evi_props
	import evi_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Bus answer, decode and reserved bits
	ready_a: assert property (psel && !penable |=> pready ##1 !pready) else $error("ready");
	unmapped_a: assert property (pready && paddr > EVI_OFS_MASKED |-> pslverr && prdata == 32'h0) else $error("map");
	mapped_a: assert property (pready && paddr == EVI_OFS_RAW |-> !pslverr) else $error("ro err");
	idle_a: assert property (!pready |-> prdata == 32'h0) else $error("idle");
	resv_zero_a: assert property (pready && paddr >= EVI_OFS_IRQ_EN |-> prdata[31:4] == 28'h0) else $error("resv");
	err_ready_a: assert property (pslverr |-> pready) else $error("err");
	// A latch that never holds would let the line drop with no write behind it
	reset_quiet_a: assert property ($rose(presetn) |-> !irq && !pready) else $error("reset");
	irq_hold_a: assert property (irq && !(psel && pwrite) |=> irq) else $error("irq");
endmodule // evi_props

// ---- verification/evi_encoder_model.sv ----
// Purpose: encoder side, count and event pulses
// Assumes: event pulses are one pclk wide; pulse_on may be held for many cycles
// Notes: outputs follow the requests by one edge
`timescale 1ns/1ps
module evi_encoder_model (
	input wire logic pclk,
	input wire logic [3:0] fire,
	input wire logic pulse_on,
	output logic velocity_pulse = 1'b0,
	output logic phase_error_event = 1'b0,
	output logic direction_change_event = 1'b0,
	output logic index_pulse_event = 1'b0
);
	// Registered so each output is a clean copy of its request, as many cycles wide as the request
	always @(posedge pclk) begin
		velocity_pulse <= pulse_on;
		phase_error_event <= fire[3];
		direction_change_event <= fire[2];
		index_pulse_event <= fire[0];
	end
endmodule // evi_encoder_model

// ---- verification/tb_top.sv ----
// Purpose: self-checking bench
// Assumes: one APB transfer at a time
// Notes: small load keeps periods short
`timescale 1ns/1ps
module tb_top;
	import evi_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pulse_on = 0, pready, pslverr, irq;
	logic velocity_pulse, phase_error_event, direction_change_event, index_pulse_event;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] fire = 4'h0;
	int n_errors = 0, n_checks = 0;
	always #4 pclk = ~pclk;
	evi_encoder_model evi_encoder_model_inst (.pclk, .fire, .pulse_on, .velocity_pulse, .phase_error_event,
		.direction_change_event, .index_pulse_event);
	evi_velocity_irq evi_velocity_irq_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .velocity_pulse, .phase_error_event, .direction_change_event, .index_pulse_event, .irq);
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			n_errors++;
			$display("Error %0t: %h %h", $time, s, e);
		end
	endtask
	// One transfer; the wait ends on pready, the watchdog bounds it
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	// Latch, mask, clear and decode of the sources
	task t_events;
		for (int i = 0; i < 4; i++) rc(EVI_OFS_VELOCITY + 12'(4 * i), 32'h0);
		@(posedge pclk) fire <= 4'hD;
		@(posedge pclk) fire <= 4'h0;
		rc(EVI_OFS_RAW, 32'hD);
		apb(1'b1, EVI_OFS_IRQ_EN, 32'h1);
		@(posedge pclk);
		chk(irq, 32'h1);
		rc(EVI_OFS_MASKED, 32'h1);
		apb(1'b1, EVI_OFS_IRQ_EN, 32'h2);
		@(posedge pclk);
		chk(irq, 32'h0);
		apb(1'b1, EVI_OFS_MASKED, 32'h1);
		rc(EVI_OFS_RAW, 32'hC);
		rc(12'h02C, 32'h0);
		apb(1'b1, EVI_OFS_MASKED, 32'hF);
		rc(EVI_OFS_RAW, 32'h0);
		$display("event test done");
	endtask
	// Ten-cycle periods, then hold while disabled
	task t_velocity;
		apb(1'b1, EVI_OFS_LOAD, 32'h9);
		pulse_on <= 1'b1;
		apb(1'b1, EVI_OFS_CONTROL, 32'h20);
		repeat (30) @(posedge pclk);
		rc(EVI_OFS_VELOCITY, 32'hA);
		rc(EVI_OFS_RAW, 32'h2);
		apb(1'b1, EVI_OFS_CONTROL, 32'h0);
		repeat (30) @(posedge pclk);
		rc(EVI_OFS_VELOCITY, 32'hA);
		pulse_on <= 1'b0;
		apb(1'b1, EVI_OFS_CONTROL, 32'h20);
		repeat (30) @(posedge pclk);
		rc(EVI_OFS_VELOCITY, 32'h0);
		$display("velocity test done");
	endtask
	task print_verdict;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_events;
		t_velocity;
		print_verdict;
	end
	// Hang guard, far above the roughly 160 cycles needed
	initial begin
		#20000;
		n_errors++;
		print_verdict;
	end
endmodule // tb_top
bind evi_velocity_irq evi_props evi_props_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
	.pready, .pslverr, .irq);
